// [sltp_port.sv]
// request fifo and telegram port of the supply line programming link

// ----------------------------------------------------------------
// request fifo
// ----------------------------------------------------------------
module sltp_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // sltp_fifo

// ----------------------------------------------------------------
// telegram port
// ----------------------------------------------------------------
module sltp_port #(
    parameter int DEPTH       = sltp_pkg::FIFO_DEPTH,
    parameter int TICK_CYCLES = sltp_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                       CLOCK_IN,
    input  wire logic                       RESET_IN,
    // supply line comparator
    input  wire logic                       SUPPLY_HIGH_IN,
    // output pin
    input  wire logic                       OUT_PIN_IN,
    output logic                            OUT_PIN_OUT,
    output logic                            OUT_PIN_OE_N_OUT,
    // request to the register side
    output logic                            CMD_VALID_OUT,
    output logic [sltp_pkg::CMD_W-1:0]      CMD_CODE_OUT,
    output logic [sltp_pkg::ADR_W-1:0]      CMD_ADDR_OUT,
    output logic [sltp_pkg::DAT_W-1:0]      CMD_DATA_OUT,
    input  wire logic                       CMD_DONE_IN,
    input  wire logic [sltp_pkg::DAT_W-1:0] CMD_RDATA_IN,
    // status
    output logic                            ACTIVE_OUT,
    output logic                            FRAME_ERROR_OUT
);
    localparam int TW = sltp_pkg::TIME_W;
    localparam int CW = sltp_pkg::CNT_W;

    // ------------------------------------------------------------
    // tick divider and synchronisers
    // ------------------------------------------------------------
    logic [sltp_pkg::TICK_W-1:0] div_q;
    logic                        tick_q;
    logic                        sup_s1_q;
    logic                        sup_s2_q;
    logic                        sup_s3_q;
    logic                        pin_s1_q;
    logic                        pin_s2_q;
    logic                        pin_s3_q;
    logic                        sup_edge;

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == sltp_pkg::TICK_W'(TICK_CYCLES-1));
            if (div_q == sltp_pkg::TICK_W'(TICK_CYCLES-1)) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            sup_s1_q <= 1'b0;
            sup_s2_q <= 1'b0;
            sup_s3_q <= 1'b0;
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            sup_s1_q <= SUPPLY_HIGH_IN;
            sup_s2_q <= sup_s1_q;
            sup_s3_q <= sup_s2_q;
            pin_s1_q <= OUT_PIN_IN;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign sup_edge = sup_s2_q ^ sup_s3_q;

    // ------------------------------------------------------------
    // telegram receiver
    // ------------------------------------------------------------
    sltp_pkg::sltp_rx_state_t         rx_q;
    logic [TW-1:0]                    t_q;
    logic [TW-1:0]                    split_q;
    logic [TW-1:0]                    idle_q;
    logic [CW-1:0]                    nbits_q;
    logic                             mid_q;
    logic [sltp_pkg::FRAME_W-1:0]     sr_q;
    logic                             fin;
    logic [sltp_pkg::FRAME_W-1:0]     fr;
    logic [sltp_pkg::CMD_W-1:0]       f_cmd;
    logic [sltp_pkg::ADR_W-1:0]       f_adr;
    logic [sltp_pkg::DAT_W-1:0]       f_dat;
    logic                             f_ok;
    logic                             push_q;
    logic [sltp_pkg::REQ_W-1:0]       push_data_q;
    logic                             err_q;
    logic                             fifo_in_ready;
    logic                             deact_q;

    // a zero has no inner edge; the first edge before the split is the inner
    // edge of a one, the next one closes the bit
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            rx_q    <= sltp_pkg::RX_IDLE;
            t_q     <= '0;
            split_q <= '0;
            idle_q  <= '0;
            nbits_q <= '0;
            mid_q   <= 1'b0;
            sr_q    <= '0;
        end else begin
            if (tick_q && t_q != '1) begin
                t_q <= t_q + 1'b1;
            end
            case (rx_q)
                sltp_pkg::RX_IDLE: begin
                    // stall new frames while the fifo is full
                    if (sup_edge && fifo_in_ready) begin
                        rx_q <= sltp_pkg::RX_SYNC;
                        t_q  <= '0;
                    end
                end
                sltp_pkg::RX_SYNC: begin
                    // sync bit length becomes the supply bit period
                    if (sup_edge) begin
                        if (t_q >= sltp_pkg::SUP_BIT_MIN_TICKS &&
                            t_q <= sltp_pkg::SUP_BIT_MAX_TICKS) begin
                            split_q <= TW'((t_q * sltp_pkg::SPLIT_PCT) / 100);
                            idle_q  <= TW'((t_q * sltp_pkg::IDLE_PCT) / 100);
                            rx_q    <= sltp_pkg::RX_BITS;
                            nbits_q <= '0;
                            mid_q   <= 1'b0;
                        end else begin
                            rx_q <= sltp_pkg::RX_IDLE;
                        end
                        t_q <= '0;
                    end else if (t_q > sltp_pkg::SUP_BIT_MAX_TICKS) begin
                        rx_q <= sltp_pkg::RX_IDLE;
                    end
                end
                sltp_pkg::RX_BITS: begin
                    if (fin) begin
                        rx_q <= sltp_pkg::RX_IDLE;
                    end else if (sup_edge) begin
                        if (t_q < split_q && !mid_q) begin
                            mid_q <= 1'b1;
                        end else begin
                            sr_q    <= {sr_q[sltp_pkg::FRAME_W-2:0], mid_q};
                            nbits_q <= nbits_q + 1'b1;
                            mid_q   <= 1'b0;
                            t_q     <= '0;
                        end
                    end
                end
                default: begin
                    rx_q <= sltp_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // frame ends on silence or on the longest frame
    assign fin = (rx_q == sltp_pkg::RX_BITS) &&
                 (t_q > idle_q || nbits_q == sltp_pkg::WR_BITS);

    // short frames are left-aligned so fields sit at fixed places
    assign fr    = (nbits_q == sltp_pkg::HDR_BITS) ?
                   {sr_q[8:0], 15'h0000} : sr_q;
    // fields arrive most significant bit first
    assign f_cmd = fr[sltp_pkg::POS_CMD +: sltp_pkg::CMD_W];
    assign f_adr = fr[sltp_pkg::POS_ADR +: sltp_pkg::ADR_W];
    assign f_dat = fr[sltp_pkg::POS_DAT +: sltp_pkg::DAT_W];

    // parity and code checks; failures are discarded
    always_comb begin
        f_ok = 1'b0;
        if (nbits_q == sltp_pkg::HDR_BITS) begin
            f_ok = (f_cmd == sltp_pkg::CMD_READ ||
                    f_cmd == sltp_pkg::CMD_BURN ||
                    f_cmd == sltp_pkg::CMD_ERASE);
        end else if (nbits_q == sltp_pkg::WR_BITS) begin
            f_ok = (f_cmd == sltp_pkg::CMD_WRITE) &&
                   (fr[sltp_pkg::POS_DP] ==
                    !sltp_pkg::zeros_odd(f_dat, sltp_pkg::DAT_W));
        end
        if (fr[sltp_pkg::POS_CP] !=
            sltp_pkg::zeros_odd({11'h000, f_cmd}, sltp_pkg::CMD_W)) begin
            f_ok = 1'b0;
        end
        if (fr[sltp_pkg::POS_AP] !=
            sltp_pkg::zeros_odd({10'h000, f_adr}, sltp_pkg::ADR_W)) begin
            f_ok = 1'b0;
        end
    end

    // hand valid frames to the fifo; a deactivated device drops them
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            push_q      <= 1'b0;
            push_data_q <= '0;
            err_q       <= 1'b0;
        end else begin
            push_q <= fin && f_ok && !deact_q;
            err_q  <= fin && !f_ok;
            if (fin) begin
                push_data_q <= {f_cmd, f_adr, f_dat};
            end
        end
    end

    // ------------------------------------------------------------
    // request fifo
    // ------------------------------------------------------------
    logic                       req_valid;
    logic                       req_ready;
    logic [sltp_pkg::REQ_W-1:0] req_data;

    sltp_fifo #(
        .WIDTH (sltp_pkg::REQ_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (CLOCK_IN),
        .rst       (RESET_IN),
        .in_valid  (push_q),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_q),
        .out_valid (req_valid),
        .out_ready (req_ready),
        .out_data  (req_data)
    );

    // ------------------------------------------------------------
    // executor and reply transmitter
    // ------------------------------------------------------------
    sltp_pkg::sltp_ex_state_t    ex_q;
    logic [TW-1:0]               tt_q;
    logic [CW-1:0]               left_q;
    logic [15:0]                 tx_sr_q;
    logic                        is_read_q;
    logic                        is_deact_q;
    logic                        level_q;
    logic                        valid_q;
    logic [sltp_pkg::CMD_W-1:0]  code_q;
    logic [sltp_pkg::ADR_W-1:0]  addr_q;
    logic [sltp_pkg::DAT_W-1:0]  data_q;
    logic                        set_deact;
    logic [sltp_pkg::CMD_W-1:0]  r_cmd;
    logic [sltp_pkg::ADR_W-1:0]  r_adr;
    logic [sltp_pkg::DAT_W-1:0]  r_dat;

    assign req_ready = (ex_q == sltp_pkg::EX_IDLE);
    assign r_cmd = req_data[sltp_pkg::REQ_W-1 -: sltp_pkg::CMD_W];
    assign r_adr = req_data[sltp_pkg::DAT_W +: sltp_pkg::ADR_W];
    assign r_dat = req_data[sltp_pkg::DAT_W-1:0];
    assign set_deact = (ex_q == sltp_pkg::EX_TX) && tick_q && is_deact_q &&
                       left_q == sltp_pkg::TX_ACK_BITS &&
                       tt_q == sltp_pkg::OUT_BIT_TICKS - 1'b1;

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            ex_q       <= sltp_pkg::EX_IDLE;
            tt_q       <= '0;
            left_q     <= '0;
            tx_sr_q    <= '0;
            is_read_q  <= 1'b0;
            is_deact_q <= 1'b0;
            level_q    <= 1'b0;
            valid_q    <= 1'b0;
            code_q     <= '0;
            addr_q     <= '0;
            data_q     <= '0;
        end else begin
            case (ex_q)
                sltp_pkg::EX_IDLE: begin
                    if (req_valid) begin
                        code_q    <= r_cmd;
                        addr_q    <= r_adr;
                        data_q    <= r_dat;
                        is_read_q <= (r_cmd == sltp_pkg::CMD_READ);
                        if (r_cmd == sltp_pkg::CMD_WRITE &&
                            r_adr == sltp_pkg::ADR_DEACT &&
                            r_dat == sltp_pkg::DEACT_VALUE) begin
                            // handled here, still acknowledged
                            is_deact_q <= 1'b1;
                            ex_q       <= sltp_pkg::EX_TX;
                            left_q     <= sltp_pkg::TX_ACK_BITS;
                            tx_sr_q    <= '0;
                            tt_q       <= '0;
                            level_q    <= ~level_q;
                        end else begin
                            is_deact_q <= 1'b0;
                            valid_q    <= 1'b1;
                            ex_q       <= sltp_pkg::EX_USER;
                        end
                    end
                end
                sltp_pkg::EX_USER: begin
                    // acknowledge only once the request is carried out
                    if (CMD_DONE_IN) begin
                        valid_q <= 1'b0;
                        ex_q    <= sltp_pkg::EX_TX;
                        tt_q    <= '0;
                        level_q <= ~level_q;
                        if (is_read_q) begin
                            // acknowledge, data, parity
                            left_q  <= sltp_pkg::TX_READ_BITS;
                            tx_sr_q <= {1'b0, CMD_RDATA_IN,
                                        !sltp_pkg::zeros_odd(CMD_RDATA_IN,
                                            sltp_pkg::DAT_W)};
                        end else begin
                            left_q  <= sltp_pkg::TX_ACK_BITS;
                            tx_sr_q <= '0;
                        end
                    end
                end
                sltp_pkg::EX_TX: begin
                    // fixed output bit period
                    if (tick_q) begin
                        tt_q <= tt_q + 1'b1;
                        if (tt_q == sltp_pkg::OUT_ONE_TICKS - 1'b1 &&
                            tx_sr_q[15]) begin
                            level_q <= ~level_q;
                        end
                        if (tt_q == sltp_pkg::OUT_BIT_TICKS - 1'b1) begin
                            level_q <= ~level_q;
                            tt_q    <= '0;
                            tx_sr_q <= {tx_sr_q[14:0], 1'b0};
                            left_q  <= left_q - 1'b1;
                            if (left_q == sltp_pkg::TX_ACK_BITS) begin
                                ex_q <= sltp_pkg::EX_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    ex_q <= sltp_pkg::EX_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // deactivation and select pulse
    // ------------------------------------------------------------
    logic [TW-1:0] hi_q;
    logic          sel_hit;
    logic          active_q;

    // a high pulse of legal length on the released pin selects
    assign sel_hit = deact_q && pin_s3_q && !pin_s2_q &&
                     hi_q >= sltp_pkg::SEL_MIN_TICKS &&
                     hi_q <= sltp_pkg::SEL_MAX_TICKS;

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            hi_q <= '0;
        end else if (!pin_s2_q) begin
            hi_q <= '0;
        end else if (tick_q && hi_q != '1) begin
            hi_q <= hi_q + 1'b1;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            deact_q  <= 1'b0;
            active_q <= 1'b1;
        end else if (set_deact) begin
            deact_q  <= 1'b1;
            active_q <= 1'b0;
        end else if (sel_hit) begin
            deact_q  <= 1'b0;
            active_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign OUT_PIN_OUT      = level_q;
    assign OUT_PIN_OE_N_OUT = deact_q;
    assign CMD_VALID_OUT    = valid_q;
    assign CMD_CODE_OUT     = code_q;
    assign CMD_ADDR_OUT     = addr_q;
    assign CMD_DATA_OUT     = data_q;
    assign ACTIVE_OUT       = active_q;
    assign FRAME_ERROR_OUT  = err_q;

endmodule // sltp_port

// [sltp_pkg.sv]
// constants, types and helpers of the supply line telegram port
package sltp_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 8;
    localparam int TIME_W        = 12;

    // times in microseconds
    localparam int SUP_BIT_MIN_US = 1700;
    localparam int SUP_BIT_MAX_US = 1900;
    localparam int OUT_BIT_US     = 3000;
    localparam int SEL_MIN_US     = 50;
    localparam int SEL_MAX_US     = 200;

    // percentages of a bit period
    localparam int ONE_PCT   = 65;
    localparam int SPLIT_PCT = 90;
    localparam int IDLE_PCT  = 150;

    // counts of microsecond ticks
    localparam logic [TIME_W-1:0] SUP_BIT_MIN_TICKS =
        TIME_W'((SUP_BIT_MIN_US * 1000 + TICK_NS - 1) / TICK_NS);
    localparam logic [TIME_W-1:0] SUP_BIT_MAX_TICKS =
        TIME_W'((SUP_BIT_MAX_US * 1000) / TICK_NS);
    localparam logic [TIME_W-1:0] OUT_BIT_TICKS =
        TIME_W'((OUT_BIT_US * 1000) / TICK_NS);
    localparam logic [TIME_W-1:0] OUT_ONE_TICKS =
        TIME_W'((OUT_BIT_US * 1000 / TICK_NS) * ONE_PCT / 100);
    localparam logic [TIME_W-1:0] SEL_MIN_TICKS =
        TIME_W'((SEL_MIN_US * 1000 + TICK_NS - 1) / TICK_NS);
    localparam logic [TIME_W-1:0] SEL_MAX_TICKS =
        TIME_W'((SEL_MAX_US * 1000) / TICK_NS);

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int CMD_W   = 3;
    localparam int ADR_W   = 4;
    localparam int DAT_W   = 14;
    localparam int FRAME_W = 24;
    localparam int REQ_W   = CMD_W + ADR_W + DAT_W;
    localparam int CNT_W   = 5;
    localparam int FIFO_DEPTH = 4;

    localparam logic [CNT_W-1:0] HDR_BITS     = 5'h09;
    localparam logic [CNT_W-1:0] WR_BITS      = 5'h18;
    localparam logic [CNT_W-1:0] TX_ACK_BITS  = 5'h01;
    localparam logic [CNT_W-1:0] TX_READ_BITS = 5'h10;

    // positions in a left-aligned frame
    localparam int POS_CMD = 21;
    localparam int POS_CP  = 20;
    localparam int POS_ADR = 16;
    localparam int POS_AP  = 15;
    localparam int POS_DAT = 1;
    localparam int POS_DP  = 0;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [CMD_W-1:0] CMD_READ  = 3'h2;
    localparam logic [CMD_W-1:0] CMD_WRITE = 3'h3;
    localparam logic [CMD_W-1:0] CMD_BURN  = 3'h4;
    localparam logic [CMD_W-1:0] CMD_ERASE = 3'h5;
    localparam logic [ADR_W-1:0] ADR_DEACT = 4'hf;
    localparam logic [DAT_W-1:0] DEACT_VALUE = 14'h080f;

    typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_BITS} sltp_rx_state_t;
    typedef enum logic [1:0] {EX_IDLE, EX_USER, EX_TX} sltp_ex_state_t;

    // true when the low w bits of v hold an odd count of zeros
    function automatic logic zeros_odd(input logic [DAT_W-1:0] v,
                                       input int w);
        logic r;
        r = 1'b0;
        for (int i = 0; i < DAT_W; i++) begin
            if (i < w && !v[i]) begin
                r = ~r;
            end
        end
        return r;
    endfunction

endpackage

// [sltp_port_chk.sv]
// assertions on the pins of the telegram port
module sltp_port_chk #(
    parameter int TICKS = 250
) (
    input wire logic        CLOCK_IN,
    input wire logic        RESET_IN,
    input wire logic        OUT_PIN_OUT,
    input wire logic        CMD_VALID_OUT,
    input wire logic [2:0]  CMD_CODE_OUT,
    input wire logic [3:0]  CMD_ADDR_OUT,
    input wire logic [13:0] CMD_DATA_OUT,
    input wire logic        CMD_DONE_IN,
    input wire logic        ACTIVE_OUT,
    input wire logic        FRAME_ERROR_OUT
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);
    localparam int G_REST = 1050 * TICKS - 1;
    localparam int G_ONE  = 1950 * TICKS - 1;
    localparam int G_BIT  = 3000 * TICKS - 1;
    int   gap_q;
    logic lvl_q;
    // cycles since the last output toggle
    always_ff @(posedge CLOCK_IN) begin
        lvl_q <= OUT_PIN_OUT;
        gap_q <= (OUT_PIN_OUT != lvl_q) ? 0 : gap_q + 1;
    end
    sequence done_s;
        CMD_VALID_OUT && CMD_DONE_IN;
    endsequence
    a_fields_hold: assert property (
        CMD_VALID_OUT && !CMD_DONE_IN |=> CMD_VALID_OUT &&
        $stable({CMD_CODE_OUT, CMD_ADDR_OUT, CMD_DATA_OUT}))
        else $error("request changed early");
    a_valid_drop: assert property (done_s |=> !CMD_VALID_OUT)
        else $error("request kept");
    a_ack_start: assert property (
        done_s |=> OUT_PIN_OUT != $past(OUT_PIN_OUT))
        else $error("no ack");
    a_code_known: assert property (
        CMD_VALID_OUT |-> CMD_CODE_OUT inside {3'h2, 3'h3, 3'h4, 3'h5})
        else $error("bad code");
    a_err_pulse: assert property (
        FRAME_ERROR_OUT |=> !FRAME_ERROR_OUT)
        else $error("long error");
    a_no_deact: assert property (
        CMD_VALID_OUT |-> !(CMD_ADDR_OUT == 4'hf && CMD_DATA_OUT == 14'h080f))
        else $error("deactivate passed on");
    a_idle_quiet: assert property (
        !ACTIVE_OUT |-> !$rose(CMD_VALID_OUT))
        else $error("inactive request");
    a_bit_time: assert property (
        $changed(OUT_PIN_OUT) && gap_q < G_BIT + 40 * TICKS |-> gap_q inside
        {[G_REST-10:G_REST+10], [G_ONE-10:G_ONE+10], [G_BIT-10:G_BIT+10]})
        else $error("bad bit time");
endmodule // sltp_port_chk
bind sltp_port sltp_port_chk #(.TICKS(TICK_CYCLES)) chk_u (.*);

// [sltp_prog_model.sv]
// programmer model: telegrams on the supply line
module sltp_prog_model #(
    parameter int TK = 250
) (
    input  wire logic clk_in,
    output logic      sup_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial sup_out = 1'b0;
    task automatic tk(input int n);
        repeat (n * TK) @(negedge clk_in);
    endtask
    // burn level after the acknowledge, then back to low
    task automatic burn();
        tk(700);
        sup_out = 1'b1;
        tk(100000);
        sup_out = 1'b0;
        tk(2000);
    endtask
    // sync zero, then msb-first bits, each closed by a toggle
    task automatic send(input logic [23:0] f, input int n);
        sup_out = ~sup_out;
        tk(1800);
        sup_out = ~sup_out;
        for (int i = 0; i < n; i++) begin
            if (f[23 - i]) begin
                tk(1170);
                sup_out = ~sup_out;
                tk(630);
            end else begin
                tk(1800);
            end
            sup_out = ~sup_out;
        end
    endtask
endmodule // sltp_prog_model

// [sltp_port_bench.sv]
// self-checking bench of the telegram port
module sltp_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, done = 1'b0, act = 1'b0;
    logic        sup, pin, oe_n, vld, active, ferr, v_q = 1'b0, es = 1'b0;
    logic [2:0]  code;
    logic [3:0]  addr;
    logic [13:0] data, d, rdat = 14'h0000;
    logic [20:0] e, exp_q[$];
    int          n_errors = 0, comparisons = 0, cyc = 0;
    localparam int TK = 1;
    wire logic   pin_in = (oe_n !== 1'b0) ? act : pin;
    sltp_prog_model #(.TK(TK)) prog_u (.clk_in(clk), .sup_out(sup));
    sltp_port #(.TICK_CYCLES(TK)) dut_u (.CLOCK_IN(clk), .RESET_IN(rst),
        .SUPPLY_HIGH_IN(sup), .OUT_PIN_IN(pin_in), .OUT_PIN_OUT(pin),
        .OUT_PIN_OE_N_OUT(oe_n), .CMD_VALID_OUT(vld), .CMD_CODE_OUT(code),
        .CMD_ADDR_OUT(addr), .CMD_DATA_OUT(data), .CMD_DONE_IN(done),
        .CMD_RDATA_IN(rdat), .ACTIVE_OUT(active), .FRAME_ERROR_OUT(ferr));
    initial forever #2 clk = ~clk;
    task automatic chk(input string nm, input logic [20:0] s, x);
        comparisons++;
        if (s !== x) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, x, s);
        end
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic tk(input int n);
        repeat (n * TK) @(negedge clk);
    endtask
    function automatic logic [23:0] fr(logic [2:0] c, logic [3:0] a,
                                       logic [13:0] x);
        return {c, ^(~c), a, ^(~a), x, ~^(~x)};
    endfunction
    // decode n reply bits from the first output toggle
    task automatic rx(input int n, input logic [20:0] x);
        logic lv, a;
        logic [20:0] v;
        int t;
        lv = pin;
        v = '0;
        t = 0;
        for (int k = 0; k < 30000 * TK && pin === lv; k++) @(negedge clk);
        lv = pin;
        for (int k = 0; k < 5000 * TK && pin === lv; k++) begin
            @(negedge clk);
            t++;
        end
        chk("ack", 21'(t), 21'(sltp_pkg::OUT_BIT_TICKS * TK));
        for (int i = 1; i < n; i++) begin
            repeat (t / 3) @(negedge clk);
            a = pin;
            repeat (t / 2) @(negedge clk);
            v = {v[19:0], a ^ pin};
            repeat (t - t / 3 - t / 2) @(negedge clk);
        end
        chk("reply", v, x);
    endtask
    // register side, request monitor and timeout
    always @(negedge clk) begin
        done <= vld && !done;
        v_q <= vld;
        if (ferr) es <= 1'b1;
        if (vld && !v_q) begin
            e = exp_q.size() ? exp_q.pop_front() : 'x;
            chk("request", {code, addr, data}, e);
        end
        cyc++;
        if (cyc == 500000 * TK) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        void'($urandom(32'h292f_48d3));
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rdat = 14'($urandom());
        d = 14'($urandom());
        exp_q.push_back({3'h3, 4'h4, d});
        prog_u.send(fr(3'h3, 4'h4, d), 24);
        rx(1, 21'h0);
        exp_q.push_back({3'h2, 4'hb, 14'h0000});
        prog_u.send(fr(3'h2, 4'hb, 14'h0000), 9);
        rx(16, {6'h00, rdat, ~^(~rdat)});
        for (int c = 4; c < 6; c++) begin
            exp_q.push_back({3'(c), 4'h0, 14'h0000});
            prog_u.send(fr(3'(c), 4'h0, 14'h0000), 9);
            rx(1, 21'h0);
            if (c == 4) prog_u.burn();
        end
        prog_u.send(fr(3'h2, 4'h1, 14'h0000) ^ 24'h10_0000, 9);
        tk(3000);
        chk("error", 21'(es), 21'h1);
        prog_u.send(fr(3'h3, 4'hf, 14'h080f), 24);
        rx(1, 21'h0);
        tk(10);
        chk("active", 21'(active), 21'h0);
        chk("release", 21'(oe_n), 21'h1);
        prog_u.send(fr(3'h2, 4'hb, 14'h0000), 9);
        tk(4000);
        act = 1'b1;
        tk(100);
        act = 1'b0;
        tk(10);
        chk("active", 21'(active), 21'h1);
        chk("release", 21'(oe_n), 21'h0);
        final_report();
    end
endmodule // sltp_port_bench
